// *** core/rlbmc_pkg.sv ***
// Package of constants and types for the remote/local bus message control.
package rlbmc_pkg;
  localparam int STB_W       = 8;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_MAV_BIT = 4;
  localparam int PIN_SYNC_W  = 3;
  localparam logic FULL_SETTLE_RST = 1'b1;
  localparam logic REPEAT_RST      = 1'b1;

  typedef enum logic [1:0] {
    RLBMC_LOCAL  = 2'b00,
    RLBMC_REMOTE = 2'b01,
    RLBMC_LOCKED = 2'b10
  } rlbmc_mode_t;
endpackage

// *** core/rlbmc_core.sv ***
// Remote/local state, interface message handling and status byte return.
`timescale 1ns/1ps
module rlbmc_core
  import rlbmc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Bus lines from the pins
  input  wire logic             ren_pin,
  input  wire logic             ifc_pin,
  // Decoded interface messages, one-cycle pulses
  input  wire logic             my_listen_addr,
  input  wire logic             my_talk_addr,
  input  wire logic             unlisten,
  input  wire logic             untalk,
  input  wire logic             msg_gtl,
  input  wire logic             msg_llo,
  input  wire logic             msg_dcl,
  input  wire logic             msg_sdc,
  input  wire logic             msg_get,
  input  wire logic             msg_trg_cmd,
  input  wire logic             msg_tct,
  input  wire logic             msg_spe,
  input  wire logic             msg_spd,
  input  wire logic             msg_ppoll,
  input  wire logic             data_in_valid,
  // Front panel and trigger setting
  input  wire logic             key_local,
  input  wire logic             key_other,
  input  wire logic             key_analog,
  input  wire logic             set_trig_valid,
  input  wire logic             set_full_settle,
  input  wire logic             set_repeat,
  // Status
  input  wire logic [STB_W-1:0] status_cond,
  input  wire logic [STB_W-1:0] srq_enable,
  input  wire logic             out_queue_avail,
  // Outputs
  output logic                  remote_ind,
  output logic                  listen_ind,
  output logic                  talk_ind,
  output logic                  lockout_active,
  output logic                  srq_out,
  output logic [STB_W-1:0]      status_byte,
  output logic                  status_byte_valid,
  output logic                  ppoll_resp,
  output logic                  clear_pulse,
  output logic                  trigger_pulse,
  output logic                  invalidate_pulse,
  output logic                  restart_pulse,
  output logic                  controller_active,
  output logic                  data_accept,
  output logic                  talk_enable,
  output logic                  full_settle_trigger,
  output logic                  repeat_retrigger_mode,
  output logic                  single_retrigger_mode,
  output logic                  key_enable,
  output logic                  analog_enable
);

  // Pin synchronisers; the first stage feeds only the second.
  logic [PIN_SYNC_W-1:0] ren_sync_reg, ren_sync_next;
  logic [PIN_SYNC_W-1:0] ifc_sync_reg, ifc_sync_next;
  logic                  ren_reg, ren_next;
  logic                  ifc_reg, ifc_next;

  rlbmc_mode_t mode_reg, mode_next;
  logic        lockout_reg, lockout_next;
  logic        listen_reg, listen_next;
  logic        talk_reg, talk_next;
  logic        spoll_reg, spoll_next;
  logic        ctrl_reg, ctrl_next;
  logic        srq_reg, srq_next;
  logic        rem_full_reg, rem_full_next;
  logic        rem_rep_reg, rem_rep_next;
  logic        full_reg, full_next;
  logic        rep_reg, rep_next;
  logic        clr_reg, clr_next;
  logic        trg_reg, trg_next;
  logic        inv_reg, inv_next;
  logic        rst_reg, rst_next;
  logic [STB_W-1:0] stb_reg, stb_next;

  logic is_remote;
  logic go_local;
  logic go_remote;
  logic ren_fall;
  logic srq_cond;

  // Remote and listen-addressed: where SDC, GET and bus data count.
  function automatic logic remote_listener(input rlbmc_mode_t m,
                                           input logic        l);
    return (m != RLBMC_LOCAL) && l;
  endfunction

  assign is_remote = (mode_reg != RLBMC_LOCAL);
  // A change counts once the second and third stages agree.
  assign ren_fall  = ren_reg && !ren_sync_reg[1] && !ren_sync_reg[2];

  always_comb begin
    ren_sync_next = {ren_sync_reg[PIN_SYNC_W-2:0], ren_pin};
    ifc_sync_next = {ifc_sync_reg[PIN_SYNC_W-2:0], ifc_pin};
    ren_next = ren_reg;
    ifc_next = ifc_reg;
    if (ren_sync_reg[1] == ren_sync_reg[2]) begin
      ren_next = ren_sync_reg[2];
    end
    if (ifc_sync_reg[1] == ifc_sync_reg[2]) begin
      ifc_next = ifc_sync_reg[2];
    end
  end

  always_comb begin
    srq_cond  = |(status_cond & srq_enable);
    // Remote needs a fresh listen address with REN true; a listener sent
    // back to local by GTL or the local key stays local until readdressed.
    go_remote = !is_remote && ren_reg && !ren_fall
                && my_listen_addr;
    go_local  = is_remote && (ren_fall
                || (msg_gtl && listen_reg)
                || (key_local && mode_reg == RLBMC_REMOTE));
    mode_next     = mode_reg;
    lockout_next  = lockout_reg;
    listen_next   = listen_reg;
    talk_next     = talk_reg;
    spoll_next    = spoll_reg;
    ctrl_next     = ctrl_reg;
    rem_full_next = rem_full_reg;
    rem_rep_next  = rem_rep_reg;
    full_next     = full_reg;
    rep_next      = rep_reg;
    inv_next      = 1'b0;
    rst_next      = 1'b0;
    // Released the edge after the last enabled condition drops.
    srq_next      = srq_cond;
    // Device clear leaves settings alone but clears the MAV bit of the status byte.
    clr_next      = msg_dcl
                    || (msg_sdc
                    && remote_listener(mode_reg, listen_reg));
    trg_next      = remote_listener(mode_reg, listen_reg)
                    && (msg_get || msg_trg_cmd);
    // Addressing.
    if (my_listen_addr) begin
      listen_next = 1'b1;
    end else if (unlisten) begin
      listen_next = 1'b0;
    end
    if (my_talk_addr) begin
      talk_next = 1'b1;
    end else if (untalk) begin
      talk_next = 1'b0;
    end
    if (msg_tct && talk_reg) begin
      ctrl_next = 1'b1;
    end else if (my_talk_addr || my_listen_addr) begin
      ctrl_next = 1'b0;
    end
    if (msg_spe) begin
      spoll_next = 1'b1;
    end else if (msg_spd) begin
      spoll_next = 1'b0;
    end
    if (ifc_reg) begin
      listen_next = 1'b0;
      talk_next   = 1'b0;
      spoll_next  = 1'b0;
    end
    // Remote trigger setting is remembered for the next remote entry.
    if (set_trig_valid && is_remote) begin
      rem_full_next = set_full_settle;
      rem_rep_next  = set_repeat;
      full_next     = set_full_settle;
      rep_next      = set_repeat;
    end
    if (msg_llo) begin
      lockout_next = 1'b1;
    end
    if (go_local) begin
      mode_next = RLBMC_LOCAL;
      full_next = FULL_SETTLE_RST;
      rep_next  = REPEAT_RST;
    end else if (go_remote) begin
      mode_next = lockout_next ? RLBMC_LOCKED : RLBMC_REMOTE;
      full_next = rem_full_reg;
      rep_next  = rem_rep_reg;
      inv_next  = 1'b1;
      rst_next  = rem_rep_reg;
    end else if (is_remote && lockout_next) begin
      mode_next = RLBMC_LOCKED;
    end
    // Lockout survives GTL; only REN false clears it.
    // REN false beats an LLO in the same cycle, but an LLO sent with REN already false still sets lockout.
    if (ren_fall) begin
      lockout_next = 1'b0;
    end
    stb_next = status_cond;
    stb_next[STB_RQS_BIT] = srq_reg;
    if (clr_next) begin
      stb_next[STB_MAV_BIT] = 1'b0;
    end
  end

  // Pin synchronisers and their filtered levels.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ren_sync_reg <= '0;
      ifc_sync_reg <= '0;
      ren_reg      <= 1'b0;
      ifc_reg      <= 1'b0;
    end else begin
      ren_sync_reg <= ren_sync_next;
      ifc_sync_reg <= ifc_sync_next;
      ren_reg      <= ren_next;
      ifc_reg      <= ifc_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg     <= RLBMC_LOCAL;
      lockout_reg  <= 1'b0;
      listen_reg   <= 1'b0;
      talk_reg     <= 1'b0;
      spoll_reg    <= 1'b0;
      ctrl_reg     <= 1'b0;
      srq_reg      <= 1'b0;
      rem_full_reg <= FULL_SETTLE_RST;
      rem_rep_reg  <= REPEAT_RST;
      full_reg     <= FULL_SETTLE_RST;
      rep_reg      <= REPEAT_RST;
      clr_reg      <= 1'b0;
      trg_reg      <= 1'b0;
      inv_reg      <= 1'b0;
      rst_reg      <= 1'b0;
      stb_reg      <= 8'h00;
    end else begin
      mode_reg     <= mode_next;
      lockout_reg  <= lockout_next;
      listen_reg   <= listen_next;
      talk_reg     <= talk_next;
      spoll_reg    <= spoll_next;
      ctrl_reg     <= ctrl_next;
      srq_reg      <= srq_next;
      rem_full_reg <= rem_full_next;
      rem_rep_reg  <= rem_rep_next;
      full_reg     <= full_next;
      rep_reg      <= rep_next;
      clr_reg      <= clr_next;
      trg_reg      <= trg_next;
      inv_reg      <= inv_next;
      rst_reg      <= rst_next;
      stb_reg      <= stb_next;
    end
  end

  // The queue flag is ignored here; the queue owner sees clear_pulse.
  logic unused_mav;
  assign unused_mav = out_queue_avail;

  assign remote_ind        = is_remote;
  assign lockout_active    = lockout_reg;
  assign listen_ind        = listen_reg;
  assign talk_ind          = talk_reg;
  assign srq_out           = srq_reg;
  assign status_byte       = stb_reg;
  assign status_byte_valid = spoll_reg && talk_reg;
  assign ppoll_resp        = 1'b0 & msg_ppoll;
  assign clear_pulse       = clr_reg;
  assign trigger_pulse     = trg_reg;
  assign invalidate_pulse  = inv_reg;
  assign restart_pulse     = rst_reg;
  assign controller_active = ctrl_reg;
  // Data from the bus is only taken while remote and listening.
  assign data_accept = data_in_valid
                     && remote_listener(mode_reg, listen_reg);
  assign talk_enable = talk_reg && !spoll_reg;
  assign full_settle_trigger   = full_reg;
  assign repeat_retrigger_mode = rep_reg;
  assign single_retrigger_mode = !rep_reg;
  assign key_enable    = !is_remote && !(key_other && 1'b0);
  assign analog_enable = 1'b1 | key_analog;
endmodule

// *** dv/rlbmc_checker.sv ***
// Concurrent checks on the ports of the bus message control.
`timescale 1ns/1ps
module rlbmc_checker
  import rlbmc_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             arst_n,
  // Inputs
  input wire logic             ren_pin,
  input wire logic             ifc_pin,
  input wire logic             msg_dcl,
  input wire logic [STB_W-1:0] status_cond,
  input wire logic [STB_W-1:0] srq_enable,
  // Outputs
  input wire logic             remote_ind,
  input wire logic             listen_ind,
  input wire logic             talk_ind,
  input wire logic             lockout_active,
  input wire logic             srq_out,
  input wire logic             ppoll_resp,
  input wire logic             clear_pulse,
  input wire logic             trigger_pulse,
  input wire logic             full_settle_trigger,
  input wire logic             repeat_retrigger_mode,
  input wire logic             key_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // The pins pass a synchroniser, so their effect is given a short window.
  sequence s_ren_gone;
    $fell(ren_pin);
  endsequence
  sequence s_back_local;
    !remote_ind && !lockout_active;
  endsequence
  a_ppoll_silent: assert property (ppoll_resp == 1'b0)
    else $error("parallel poll answered");
  a_srq_raise: assert property (|(status_cond & srq_enable) |=> srq_out)
    else $error("service request missing");
  a_srq_release: assert property (!(|(status_cond & srq_enable)) |=> !srq_out)
    else $error("service request held");
  a_dcl_clear: assert property (msg_dcl |=> clear_pulse)
    else $error("device clear ignored");
  a_ifc_drop: assert property ($rose(ifc_pin) |-> ##[1:5] !(talk_ind || listen_ind))
    else $error("addressing kept after abort");
  a_ren_local: assert property (s_ren_gone |-> ##[1:5] s_back_local)
    else $error("remote kept after enable fell");
  a_trig_gate: assert property (trigger_pulse |-> $past(remote_ind && listen_ind))
    else $error("trigger while not remote listener");
  a_key_block: assert property (remote_ind |-> !key_enable)
    else $error("keys live in remote");
  a_exit_default: assert property ($fell(remote_ind) |-> ##[0:1] (full_settle_trigger && repeat_retrigger_mode))
    else $error("trigger not defaulted on exit");
endmodule
bind rlbmc_core rlbmc_checker u_chk (
  .clk(clk), .arst_n(arst_n), .ren_pin(ren_pin), .ifc_pin(ifc_pin),
  .msg_dcl(msg_dcl), .status_cond(status_cond), .srq_enable(srq_enable),
  .remote_ind(remote_ind), .listen_ind(listen_ind), .talk_ind(talk_ind),
  .lockout_active(lockout_active), .srq_out(srq_out),
  .ppoll_resp(ppoll_resp), .clear_pulse(clear_pulse),
  .trigger_pulse(trigger_pulse), .full_settle_trigger(full_settle_trigger),
  .repeat_retrigger_mode(repeat_retrigger_mode), .key_enable(key_enable)
);

// *** dv/rlbmc_ctrl_model.sv ***
// Bus controller model driving the lines and decoded message pulses.
`timescale 1ns/1ps
module rlbmc_ctrl_model (
  // Clock
  input  wire logic   clk,
  // Bus lines and messages
  output logic        ren,
  output logic        ifc,
  output logic [17:0] msg
);
  initial begin
    ren = 1'b0;
    ifc = 1'b0;
    msg = 18'h00000;
  end
  // One pulse, then a quiet cycle so calls never collide on one edge.
  task automatic send(input int b);
    msg <= 18'h00001 << b;
    @(posedge clk);
    msg <= 18'h00000;
    @(posedge clk);
  endtask
  // Remote enable is held while addressing so the device may go remote.
  task automatic set_lines(input logic r, input logic i);
    ren <= r;
    ifc <= i;
    repeat (6) @(posedge clk);
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench for the bus message control.
`timescale 1ns/1ps
module tb_top
  import rlbmc_pkg::*;
;
  localparam int LSN = 0, TLK = 1, GTL = 4, LLO = 5, DCL = 6, SDC = 7;
  localparam int GET = 8, TRG = 9, TCT = 10, SPE = 11, PPL = 13, KLO = 15;
  localparam int DAT = 14;
  logic clk = 1'b0, arst_n = 1'b0, ren, ifc;
  logic [17:0] msg;
  logic [7:0] cond = 8'h00, sre = 8'h00, stb;
  logic rem, lsn, tlk, lko, srq, stv, clr, trg, inv, ctl, fst, rpt, ken;
  logic rsp, dac, ten, sgl, ana, trv = 1'b0, tfs = 1'b0, trp = 1'b0;
  int num_errors = 0, compares = 0, n_clr = 0, n_trg = 0, n_inv = 0, cyc = 0;
  int n_rst = 0, n_dat = 0;
  rlbmc_ctrl_model m (.clk(clk), .ren(ren), .ifc(ifc), .msg(msg));
  rlbmc_core DUT (
    .clk(clk), .arst_n(arst_n), .ren_pin(ren), .ifc_pin(ifc),
    .my_listen_addr(msg[0]), .my_talk_addr(msg[1]), .unlisten(msg[2]),
    .untalk(msg[3]), .msg_gtl(msg[4]), .msg_llo(msg[5]), .msg_dcl(msg[6]),
    .msg_sdc(msg[7]), .msg_get(msg[8]), .msg_trg_cmd(msg[9]),
    .msg_tct(msg[10]), .msg_spe(msg[11]), .msg_spd(msg[12]),
    .msg_ppoll(msg[13]), .data_in_valid(msg[14]), .key_local(msg[15]),
    .key_other(msg[16]), .key_analog(msg[17]), .set_trig_valid(trv),
    .set_full_settle(tfs), .set_repeat(trp), .status_cond(cond),
    .srq_enable(sre), .out_queue_avail(1'b0), .remote_ind(rem),
    .listen_ind(lsn), .talk_ind(tlk), .lockout_active(lko), .srq_out(srq),
    .status_byte(stb), .status_byte_valid(stv), .ppoll_resp(),
    .clear_pulse(clr), .trigger_pulse(trg), .invalidate_pulse(inv),
    .restart_pulse(rsp), .controller_active(ctl), .data_accept(dac),
    .talk_enable(ten), .full_settle_trigger(fst), .repeat_retrigger_mode(rpt),
    .single_retrigger_mode(sgl), .key_enable(ken), .analog_enable(ana)
  );
  initial forever #50 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Pulses are counted mid-cycle, away from the edge that launches them.
  always @(negedge clk) begin
    cyc++;
    n_clr += (clr === 1'b1);
    n_trg += (trg === 1'b1);
    n_inv += (inv === 1'b1);
    n_rst += (rsp === 1'b1);
    n_dat += (dac === 1'b1);
    if (cyc == 2000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("reset", {rem, lko, fst, rpt, ken}, 8'h07);
    m.set_lines(1'b1, 1'b0);
    m.send(GET);
    chk("trig refused", n_trg, 0);
    m.send(LSN);
    chk("remote", {rem, lsn, ken}, 8'h06);
    chk("invalidate", n_inv, 1);
    chk("restart", n_rst, 1);
    chk("analog", ana, 1);
    m.send(GET);
    m.send(TRG);
    m.send(PPL);
    chk("triggers", n_trg, 2);
    m.send(DAT);
    m.send(DCL);
    m.send(SDC);
    chk("clears", n_clr, 2);
    chk("kept", rem, 1);
    trv <= 1'b1;
    @(posedge clk);
    trv <= 1'b0;
    @(posedge clk);
    chk("remote setting", {fst, rpt, sgl}, 8'h01);
    m.send(GTL);
    chk("gtl", {rem, fst, rpt}, 8'h03);
    m.send(DAT);
    chk("data", n_dat, 1);
    $display("test remote done");
    m.send(LLO);
    m.send(LSN);
    m.send(KLO);
    chk("locked", {rem, lko, ken}, 8'h06);
    chk("restore", {fst, rpt}, 8'h00);
    chk("single wait", n_rst, 1);
    chk("invalidate 2", n_inv, 2);
    m.send(GTL);
    chk("gtl locked", {rem, lko}, 8'h01);
    m.set_lines(1'b0, 1'b0);
    chk("ren off", {rem, lko}, 8'h00);
    m.set_lines(1'b1, 1'b0);
    m.send(LSN);
    chk("remote again", rem, 1);
    m.send(KLO);
    chk("local key", rem, 0);
    $display("test lockout done");
    cond <= 8'h05;
    sre <= 8'h04;
    m.send(TLK);
    chk("talk", {ten, tlk}, 8'h03);
    m.send(SPE);
    chk("srq", srq, 1);
    chk("poll", {stv, tlk, stb[STB_RQS_BIT]}, 8'h07);
    chk("status", stb, 8'h45);
    chk("talk held", ten, 0);
    sre <= 8'h00;
    m.send(TCT);
    chk("srq off", srq, 0);
    chk("control", ctl, 1);
    m.send(LSN);
    m.set_lines(1'b1, 1'b1);
    chk("abort", {lsn, tlk}, 8'h00);
    $display("test talker done");
    report_and_stop;
  end
endmodule
